// file: rtl/isi_pkg.sv
/*
 * shared constants of the interrupt source identifier: register offsets,
 * field positions, reset values and bus answer codes.
 * assumes a 32-bit AXI4-Lite register bus with byte addresses.
 */
`default_nettype none
package isi_pkg;
   // ----------------------------------------------------------------
   // bus geometry
   // ----------------------------------------------------------------
   localparam int             ADDR_W       = 4;      // byte address bits
   localparam int             DATA_W       = 32;     // bus data width
   localparam int             ID_W         = 8;      // identify width

   // ----------------------------------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFF_IDENTIFY = 4'h0; // read only
   localparam logic [ADDR_W-1:0] OFF_STATUS   = 4'h4; // sticky, w1c
   localparam logic [ADDR_W-1:0] OFF_MASK     = 4'h8; // irq enables

   // ----------------------------------------------------------------
   // field layout of identify, status and mask
   // ----------------------------------------------------------------
   localparam int             NUM_MOD      = 6;      // modules 0 to 5
   localparam int             BIT_RSVD     = 6;      // always zero in identify and status; mask bit 6 is writable
   localparam int             BIT_SYS      = 7;      // system modules

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [ID_W-1:0] RST_IDENTIFY = 8'h00;
   localparam logic [ID_W-1:0] RST_STATUS   = 8'h00;
   localparam logic [ID_W-1:0] RST_MASK     = 8'h00;

   // ----------------------------------------------------------------
   // bus answer codes
   // ----------------------------------------------------------------
   localparam logic [1:0]     RESP_OKAY    = 2'h0;
   localparam logic [1:0]     RESP_SLVERR  = 2'h2;
endpackage
`default_nettype wire

// file: rtl/isi_axil_slave.sv
/*
 * AXI4-Lite slave front end: takes write address and data in either
 * order, gives one write strobe and one read sample to the register file.
 * assumes the register file decodes rd_addr combinationally.
 */
`timescale 1ns/100ps
`default_nettype none
module isi_axil_slave
   import isi_pkg::*;
(
   input  wire logic                       clk,
   input  wire logic                       rst,
   input  wire logic [isi_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                       awvalid,
   output logic                            awready,
   input  wire logic [isi_pkg::DATA_W-1:0] wdata,
   input  wire logic [3:0]                 wstrb,
   input  wire logic                       wvalid,
   output logic                            wready,
   output logic [1:0]                      bresp,
   output logic                            bvalid,
   input  wire logic                       bready,
   input  wire logic [isi_pkg::ADDR_W-1:0] araddr,
   input  wire logic                       arvalid,
   output logic                            arready,
   output logic [isi_pkg::DATA_W-1:0]      rdata,
   output logic [1:0]                      rresp,
   output logic                            rvalid,
   input  wire logic                       rready,
   output logic                            wr_en,     // one-cycle write strobe
   output logic [isi_pkg::ADDR_W-1:0]      wr_addr,
   output logic [isi_pkg::DATA_W-1:0]      wr_data,
   output logic [3:0]                      wr_strb,
   input  wire logic                       wr_err,    // unmapped write address
   output logic [isi_pkg::ADDR_W-1:0]      rd_addr,
   input  wire logic [isi_pkg::DATA_W-1:0] rd_data,
   input  wire logic                       rd_err     // unmapped read address
);
   import isi_pkg::*;

   logic aw_held_reg;                       // write address captured
   logic w_held_reg;                        // write data captured

   // ----------------------------------------------------------------
   // handshakes
   // ----------------------------------------------------------------
   // no new write is taken while a response waits, so at most one
   // write is ever outstanding
   assign awready = !aw_held_reg && !bvalid;
   assign wready  = !w_held_reg && !bvalid;
   assign arready = !rvalid;
   assign wr_en   = aw_held_reg && w_held_reg && !bvalid;
   assign rd_addr = araddr;

   // address channel of a write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         aw_held_reg <= 1'b0;
         wr_addr     <= '0;
      end else if (awvalid && awready) begin
         aw_held_reg <= 1'b1;
         wr_addr     <= awaddr;
      end else if (wr_en) begin
         aw_held_reg <= 1'b0;
      end
   end

   // data channel of a write
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         w_held_reg <= 1'b0;
         wr_data    <= '0;
         wr_strb    <= 4'h0;
      end else if (wvalid && wready) begin
         w_held_reg <= 1'b1;
         wr_data    <= wdata;
         wr_strb    <= wstrb;
      end else if (wr_en) begin
         w_held_reg <= 1'b0;
      end
   end

   // write response, one cycle after both halves are held
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else if (wr_en) begin
         bvalid <= 1'b1;
         bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end else if (bready) begin
         bvalid <= 1'b0;
      end
   end

   // read answer, sampled at the address handshake
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rvalid <= 1'b0;
         rdata  <= '0;
         rresp  <= RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata  <= rd_data;
         rresp  <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end else if (rready) begin
         rvalid <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// file: rtl/isi_top.sv
/*
 * interrupt source identifier: folds the enabled, pending sources of six
 * peripheral register modules and the system modules into one read-only
 * identify byte, with sticky status, mask and one interrupt line.
 * assumes source flags and enables come from logic on CLK.
 */
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// [R1] identify clears to zero on every reset
// [R2] bits 0 to 5 flag modules 0 to 5
// [R3] top bit flags any pending system module
// [R4] flag only enabled and pending sources count
// [R5] flag drops when sources disabled or cleared
// [R6] bit six always reads zero
// [R7] software writes to identify are ignored
module isi_top
   import isi_pkg::*;
#(
   parameter int SRC_PER_MOD = 8,           // sources per module, max 32
   parameter int SYS_SRC     = 4            // system sources, max 32
)(
   input  wire logic                                     CLK,
   input  wire logic                                     RST,
   input  wire logic [isi_pkg::NUM_MOD*SRC_PER_MOD-1:0] MOD_SRC_FLAG,
   input  wire logic [isi_pkg::NUM_MOD*SRC_PER_MOD-1:0] MOD_SRC_EN,
   input  wire logic [SYS_SRC-1:0]                       SYS_SRC_FLAG,
   input  wire logic [SYS_SRC-1:0]                       SYS_SRC_EN,
   output logic [isi_pkg::ID_W-1:0]                      IDENTIFY,
   output logic                                          IRQ,
   input  wire logic [isi_pkg::ADDR_W-1:0]               S_AXI_AWADDR,
   input  wire logic                                     S_AXI_AWVALID,
   output logic                                          S_AXI_AWREADY,
   input  wire logic [isi_pkg::DATA_W-1:0]               S_AXI_WDATA,
   input  wire logic [3:0]                               S_AXI_WSTRB,
   input  wire logic                                     S_AXI_WVALID,
   output logic                                          S_AXI_WREADY,
   output logic [1:0]                                    S_AXI_BRESP,
   output logic                                          S_AXI_BVALID,
   input  wire logic                                     S_AXI_BREADY,
   input  wire logic [isi_pkg::ADDR_W-1:0]               S_AXI_ARADDR,
   input  wire logic                                     S_AXI_ARVALID,
   output logic                                          S_AXI_ARREADY,
   output logic [isi_pkg::DATA_W-1:0]                    S_AXI_RDATA,
   output logic [1:0]                                    S_AXI_RRESP,
   output logic                                          S_AXI_RVALID,
   input  wire logic                                     S_AXI_RREADY
);
   import isi_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [ID_W-1:0]   identify_reg;         // live pending picture
   logic [ID_W-1:0]   identify_next;
   logic [ID_W-1:0]   status_reg;           // sticky rise events
   logic [ID_W-1:0]   status_next;
   logic [ID_W-1:0]   mask_reg;             // interrupt enables
   logic [ID_W-1:0]   mask_next;
   logic [ID_W-1:0]   rise;                 // flags newly raised
   logic [ID_W-1:0]   w1c;                  // status bits to clear
   logic              wr_en;                // register write strobe
   logic [ADDR_W-1:0] wr_addr;
   logic [DATA_W-1:0] wr_data;
   logic [3:0]        wr_strb;
   logic              wr_err;               // write to no register
   logic [ADDR_W-1:0] rd_addr;
   logic [DATA_W-1:0] rd_data;
   logic              rd_err;               // read of no register

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // a source counts only when it is both flagged and enabled
   function automatic logic any_pending(input logic [31:0] flag,
                                        input logic [31:0] en);
      any_pending = |(flag & en);           // R4
   endfunction

   // word compare of a byte address; the low two bits must be zero
   function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                input logic [ADDR_W-1:0] off);
      hit = (addr[ADDR_W-1:2] == off[ADDR_W-1:2]) && (addr[1:0] == 2'h0);
   endfunction

   // ----------------------------------------------------------------
   // bus front end
   // ----------------------------------------------------------------
   isi_axil_slave u_slave (
      .clk     (CLK),
      .rst     (RST),
      .awaddr  (S_AXI_AWADDR),
      .awvalid (S_AXI_AWVALID),
      .awready (S_AXI_AWREADY),
      .wdata   (S_AXI_WDATA),
      .wstrb   (S_AXI_WSTRB),
      .wvalid  (S_AXI_WVALID),
      .wready  (S_AXI_WREADY),
      .bresp   (S_AXI_BRESP),
      .bvalid  (S_AXI_BVALID),
      .bready  (S_AXI_BREADY),
      .araddr  (S_AXI_ARADDR),
      .arvalid (S_AXI_ARVALID),
      .arready (S_AXI_ARREADY),
      .rdata   (S_AXI_RDATA),
      .rresp   (S_AXI_RRESP),
      .rvalid  (S_AXI_RVALID),
      .rready  (S_AXI_RREADY),
      .wr_en   (wr_en),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .wr_strb (wr_strb),
      .wr_err  (wr_err),
      .rd_addr (rd_addr),
      .rd_data (rd_data),
      .rd_err  (rd_err)
   );

   // ----------------------------------------------------------------
   // pending picture
   // ----------------------------------------------------------------
   // rebuilt every cycle from the sources, so it falls as soon as a
   // source is disabled or its flag cleared; no memory of its own
   always_comb begin
      identify_next = '0;
      for (int m = 0; m < NUM_MOD; m++) begin
         identify_next[m] = any_pending(
            32'(MOD_SRC_FLAG[m*SRC_PER_MOD +: SRC_PER_MOD]),
            32'(MOD_SRC_EN[m*SRC_PER_MOD +: SRC_PER_MOD]));  // R2 R5
      end
      identify_next[BIT_RSVD] = 1'b0;                         // R6
      identify_next[BIT_SYS]  = any_pending(32'(SYS_SRC_FLAG),
                                            32'(SYS_SRC_EN)); // R3
   end

   // identify register; no bus path reaches it
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         identify_reg <= RST_IDENTIFY;      // R1
      end else begin
         identify_reg <= identify_next;     // R7
      end
   end

   assign IDENTIFY = identify_reg;

   // ----------------------------------------------------------------
   // sticky status and mask
   // ----------------------------------------------------------------
   // a flag rising is an event; the reserved bit never rises
   assign rise = identify_next & ~identify_reg;

   // write-one-to-clear mask of the current write, low byte only
   always_comb begin
      w1c = '0;
      if (wr_en && hit(wr_addr, OFF_STATUS) && wr_strb[0]) begin
         w1c = wr_data[ID_W-1:0];
      end
   end

   // an event in the clearing cycle survives: set wins over clear
   assign status_next = (status_reg & ~w1c) | rise;

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         status_reg <= RST_STATUS;
      end else begin
         status_reg <= status_next;
      end
   end

   // mask keeps its value unless the low byte is written
   always_comb begin
      mask_next = mask_reg;
      if (wr_en && hit(wr_addr, OFF_MASK) && wr_strb[0]) begin
         mask_next = wr_data[ID_W-1:0];
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         mask_reg <= RST_MASK;
      end else begin
         mask_reg <= mask_next;
      end
   end

   // level line, registered so it never glitches
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(status_next & mask_next);
      end
   end

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   // a write to identify is accepted with OKAY and has no effect
   assign wr_err = !(hit(wr_addr, OFF_IDENTIFY) ||
                     hit(wr_addr, OFF_STATUS)   ||
                     hit(wr_addr, OFF_MASK));           // R7

   // read mux; unmapped addresses answer zero with an error
   always_comb begin
      rd_data = '0;
      rd_err  = 1'b0;
      if (hit(rd_addr, OFF_IDENTIFY)) begin
         rd_data[ID_W-1:0] = identify_reg;
      end else if (hit(rd_addr, OFF_STATUS)) begin
         rd_data[ID_W-1:0] = status_reg;
      end else if (hit(rd_addr, OFF_MASK)) begin
         rd_data[ID_W-1:0] = mask_reg;
      end else begin
         rd_err = 1'b1;
      end
   end
endmodule
`default_nettype wire

// file: verif/isi_src_model.sv
/*
 * behavioural model of the peripheral register modules and system modules:
 * holds source flags and enables, loaded by the bench in one cycle.
 * assumes the bench raises load for a single cycle after a clock edge.
 */
`timescale 1ns/100ps
`default_nettype none
module isi_src_model
   import isi_pkg::*;
#(
   parameter int SPM = 8,                  // sources per module
   parameter int NS  = 4                   // system sources
)(
   input  wire logic                            clk,
   input  wire logic                            load,
   input  wire logic [isi_pkg::NUM_MOD*SPM-1:0] f_in,
   input  wire logic [isi_pkg::NUM_MOD*SPM-1:0] e_in,
   input  wire logic [NS-1:0]                   sf_in,
   input  wire logic [NS-1:0]                   se_in,
   output logic      [isi_pkg::NUM_MOD*SPM-1:0] mod_flag,
   output logic      [isi_pkg::NUM_MOD*SPM-1:0] mod_en,
   output logic      [NS-1:0]                   sys_flag,
   output logic      [NS-1:0]                   sys_en
);
   import isi_pkg::*;

   // ---------------------------------------------
   // source state
   // ---------------------------------------------
   // no reset on purpose: sources stay pending across a device reset,
   // so the identify byte must clear on its own
   initial begin
      mod_flag = '0;
      mod_en   = '0;
      sys_flag = '0;
      sys_en   = '0;
   end
   always @(posedge clk) begin
      if (load) begin
         mod_flag <= f_in;
         mod_en   <= e_in;
         sys_flag <= sf_in;
         sys_en   <= se_in;
      end
   end
endmodule
`default_nettype wire

// file: verif/isi_top_props.sv
/*
 * checker for the identify byte and the register bus answers.
 * assumes one clock and the asynchronous active high reset of the top.
 */
`timescale 1ns/100ps
`default_nettype none
module isi_props_chk
   import isi_pkg::*;
#(
   parameter int SRC_PER_MOD = 8,
   parameter int SYS_SRC     = 4
)(
   input  wire logic                                     CLK,
   input  wire logic                                     RST,
   input  wire logic [isi_pkg::NUM_MOD*SRC_PER_MOD-1:0] MOD_SRC_FLAG,
   input  wire logic [isi_pkg::NUM_MOD*SRC_PER_MOD-1:0] MOD_SRC_EN,
   input  wire logic [SYS_SRC-1:0]                       SYS_SRC_FLAG,
   input  wire logic [SYS_SRC-1:0]                       SYS_SRC_EN,
   input  wire logic [isi_pkg::ID_W-1:0]                 IDENTIFY,
   input  wire logic                                     IRQ,
   input  wire logic                                     S_AXI_AWVALID,
   input  wire logic                                     S_AXI_AWREADY,
   input  wire logic                                     S_AXI_WVALID,
   input  wire logic                                     S_AXI_WREADY,
   input  wire logic                                     S_AXI_BVALID,
   input  wire logic                                     S_AXI_BREADY,
   input  wire logic [1:0]                               S_AXI_BRESP,
   input  wire logic                                     S_AXI_ARVALID,
   input  wire logic                                     S_AXI_ARREADY,
   input  wire logic                                     S_AXI_RVALID,
   input  wire logic                                     S_AXI_RREADY,
   input  wire logic [isi_pkg::DATA_W-1:0]               S_AXI_RDATA
);
   import isi_pkg::*;

   // ---------------------------------------------
   // per-module pending, enabled and flagged
   // ---------------------------------------------
   logic [NUM_MOD-1:0] mod_pend;           // expected module bits
   always_comb begin
      for (int m = 0; m < NUM_MOD; m++) begin
         mod_pend[m] = |(MOD_SRC_FLAG[m*SRC_PER_MOD +: SRC_PER_MOD]
                       & MOD_SRC_EN[m*SRC_PER_MOD +: SRC_PER_MOD]);
      end
   end
   // expected system bit, kept as a signal so that $past sees a name
   logic               sys_pend;
   assign sys_pend = |(SYS_SRC_FLAG & SYS_SRC_EN);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   rst_clear_a: assert property ($fell(RST) |-> IDENTIFY == 8'h00)
      else $error("identify not clear after reset");
   mod_flag_a: assert property (!$past(RST) |-> IDENTIFY[5:0] == $past(mod_pend))
      else $error("module flags differ from enabled pending sources");
   mod_drop_a: assert property (mod_pend == '0 |=> IDENTIFY[5:0] == 6'h00)
      else $error("module flag stays after sources quiet");
   sys_flag_a: assert property (!$past(RST) |-> IDENTIFY[BIT_SYS] == $past(sys_pend))
      else $error("system flag wrong");
   rsvd_zero_a: assert property (IDENTIFY[BIT_RSVD] == 1'b0)
      else $error("reserved identify bit set");
   wr_answer_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID
      && S_AXI_WREADY |-> ##[1:3] S_AXI_BVALID)
      else $error("write answer late");
   rd_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("read answer late");
   b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
      S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write answer dropped");
   r_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
      S_AXI_RVALID && $stable(S_AXI_RDATA))
      else $error("read answer dropped");
   cover property (IRQ);
   cover property (S_AXI_BVALID && S_AXI_BRESP == RESP_SLVERR);
   cover property ($rose(IDENTIFY[BIT_SYS]));
endmodule
bind isi_top isi_props_chk #(.SRC_PER_MOD(SRC_PER_MOD), .SYS_SRC(SYS_SRC)) i_chk (
   .CLK, .RST, .MOD_SRC_FLAG, .MOD_SRC_EN, .SYS_SRC_FLAG, .SYS_SRC_EN, .IDENTIFY,
   .IRQ, .S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID,
   .S_AXI_BREADY, .S_AXI_BRESP, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RVALID,
   .S_AXI_RREADY, .S_AXI_RDATA);
`default_nettype wire

// file: verif/interrupt_source_identifier_tb.sv
/*
 * self-checking bench: random sources, bus reads of all registers,
 * interrupt raise, mask and clear, a reset in mid-run.
 * assumes the source model and the checker of this folder.
 */
`timescale 1ns/100ps
`default_nettype none
module interrupt_source_identifier_tb;
   import isi_pkg::*;
   localparam int SPM = 8;
   localparam int NS  = 4;
   localparam int MW  = NUM_MOD*SPM;
   logic CLK = 1'b0, RST = 1'b1, load = 1'b0, irq;
   logic [MW-1:0] f_in = '0, e_in = '0, mf, me, f, e;
   logic [NS-1:0] sf_in = '0, se_in = '0, sf, se, s, t;
   logic [3:0]    awaddr = '0, araddr = '0, wstrb = '0;
   logic [31:0]   wdata = '0, rdata;
   logic          awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic          awready, wready, bvalid, arready, rvalid;
   logic [1:0]    bresp, rresp;
   logic [7:0]    ident;
   logic [33:0]   rq[$];                  // expected read answers
   logic [1:0]    bq[$];                  // expected write answers
   int            num_errors = 0, n_compared = 0;
   initial forever #25 CLK = ~CLK;
   isi_src_model #(.SPM(SPM), .NS(NS)) i_src (.clk(CLK), .load, .f_in, .e_in, .sf_in,
      .se_in, .mod_flag(mf), .mod_en(me), .sys_flag(sf), .sys_en(se));
   isi_top #(.SRC_PER_MOD(SPM), .SYS_SRC(NS)) i_dut (.CLK, .RST, .MOD_SRC_FLAG(mf),
      .MOD_SRC_EN(me), .SYS_SRC_FLAG(sf), .SYS_SRC_EN(se), .IDENTIFY(ident), .IRQ(irq),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
      .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
      .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
   // ---------------------------------------------
   // shared helpers
   // ---------------------------------------------
   task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("errors %0d, comparisons %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   function automatic logic [33:0] ok(input logic [7:0] v);
      return {RESP_OKAY, 24'h0, v};
   endfunction
   function automatic logic [7:0] exp_id(input logic [MW-1:0] a, b, input logic [NS-1:0] c, d);
      logic [7:0] r;
      r = '0;
      for (int m = 0; m < NUM_MOD; m++) r[m] = |(a[m*SPM +: SPM] & b[m*SPM +: SPM]);
      r[BIT_SYS] = |(c & d);
      return r;
   endfunction
   // model load, then identify settles one cycle after the model
   task automatic drive(input logic [MW-1:0] a, b, input logic [NS-1:0] c, d);
      f_in  <= a;
      e_in  <= b;
      sf_in <= c;
      se_in <= d;
      load  <= 1'b1;
      @(posedge CLK) load <= 1'b0;
      repeat (2) @(posedge CLK);
      cmp({26'h0, ident}, {26'h0, exp_id(a, b, c, d)});
   endtask
   // ---------------------------------------------
   // bus master, answers stalled at random
   // ---------------------------------------------
   task automatic axw(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r);
      int n, st;
      st = $urandom_range(1, 4);
      bq.push_back(r);
      awaddr  <= a;
      wdata   <= {24'h0, d};
      wstrb   <= 4'hF;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge CLK);
         if (bvalid && bready) break;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (n == st) bready <= 1'b1;
      end
      bready <= 1'b0;
      if (n == 40) begin
         num_errors++;
         wrap_up();
      end
      @(posedge CLK);
   endtask
   task automatic axr(input logic [3:0] a, input logic [33:0] x);
      int n, st;
      st = $urandom_range(0, 3);
      rq.push_back(x);
      araddr <= a; arvalid <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge CLK);
         if (rvalid && rready) break;
         if (arvalid && arready) arvalid <= 1'b0;
         if (n == st) rready <= 1'b1;
      end
      rready <= 1'b0;
      if (n == 40) begin
         num_errors++;
         wrap_up();
      end
      @(posedge CLK);
   endtask
   // watcher: each answer against the oldest note
   always @(posedge CLK) begin
      if (bvalid && bready) cmp({32'h0, bresp}, {32'h0, bq.pop_front()});
      if (rvalid && rready) cmp({rresp, rdata}, rq.pop_front());
   end
   // ---------------------------------------------
   // main sequence
   // ---------------------------------------------
   initial begin
      void'($urandom(51));
      repeat (2) @(posedge CLK);
      RST <= 1'b0;
      @(posedge CLK);
      axr(OFF_IDENTIFY, ok(RST_IDENTIFY));
      axr(OFF_STATUS, ok(RST_STATUS));
      axr(OFF_MASK, ok(RST_MASK));
      for (int i = 0; i < 24; i++) begin
         f = MW'({$urandom, $urandom});
         e = (i % 4 == 0) ? '0 : MW'({$urandom, $urandom});
         s = NS'($urandom);
         t = NS'($urandom);
         drive(f, e, s, t);
         axr(OFF_IDENTIFY, ok(exp_id(f, e, s, t)));
      end
      drive('1, '1, '1, '1);
      drive('1, '0, '1, '0);
      drive('1, '1, '1, '1);
      axw(OFF_IDENTIFY, 8'h00, RESP_OKAY);
      axr(OFF_IDENTIFY, ok(8'hBF));
      drive('0, '1, '0, '1);
      axw(4'hC, 8'hFF, RESP_SLVERR);
      axr(4'hC, {RESP_SLVERR, 32'h0});
      axw(OFF_STATUS, 8'hFF, RESP_OKAY);
      axr(OFF_STATUS, ok(8'h00));
      axw(OFF_MASK, 8'h01, RESP_OKAY);
      axr(OFF_MASK, ok(8'h01));
      drive(MW'(1), MW'(1), '0, '0);
      cmp({33'h0, irq}, 34'h1);
      axr(OFF_STATUS, ok(8'h01));
      axw(OFF_MASK, 8'h00, RESP_OKAY);
      cmp({33'h0, irq}, 34'h0);
      axw(OFF_MASK, 8'h01, RESP_OKAY);
      cmp({33'h0, irq}, 34'h1);
      axw(OFF_STATUS, 8'h01, RESP_OKAY);
      cmp({33'h0, irq}, 34'h0);
      axr(OFF_STATUS, ok(8'h00));
      // reset with sources still pending
      drive('1, '1, '1, '1);
      RST <= 1'b1;
      repeat (2) @(posedge CLK);
      cmp({26'h0, ident}, {26'h0, RST_IDENTIFY});
      RST <= 1'b0;
      repeat (3) @(posedge CLK);
      cmp({26'h0, ident}, 34'hBF);
      // mask restarts cleared; the post-reset rise of each flag is an event
      axr(OFF_MASK, ok(RST_MASK));
      axr(OFF_STATUS, ok(8'hBF));
      cmp({33'h0, irq}, 34'h0);
      wrap_up();
   end
endmodule
`default_nettype wire
